// file: rtl/flash_prog_host.sv
// Programmer controller driving the flash programming port of the target device
// Functional notes
// - Hold reset high, latch strobe low, store strobe high during every operation.
// - Address on ports 2 and 1, upper byte on port 2; data on port 0.
// - Program: program supply, chip select low, output gate high; byte written.
// - After each program, verify with select high, gate low and compare.
// - Erase: erase-select high, erase supply, select low, gate high, A0 low, data FFh.
// - After erase, verify each byte with erase-select high, erase supply, select high.
// - Other port 3 control pins low, erase-select free only in inhibit.
`timescale 1ns/1ps
`default_nettype none
module flash_prog_host #(
    parameter logic [15:0] HOLD_DEFAULT = flash_prog_pkg::HOLD_RESET
) (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output flash_prog_pkg::ctrl_pins_t PINS_OUT,
    output logic [15:0] ADDR_OUT,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE_N_OUT,
    input wire logic [7:0] DATA_IN
);
    // ****************************************
    // Register file
    // ****************************************
    flash_prog_pkg::flash_op_t op_reg;
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [15:0] hold_reg;
    logic done_reg;
    logic mismatch_reg;
    flash_prog_pkg::seq_state_t state_reg;
    logic [15:0] count_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] last_prog_reg;

    logic wr;
    logic start;
    logic busy;
    assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign busy = (state_reg != flash_prog_pkg::ST_IDLE);
    assign start = wr && (PADDR_IN == flash_prog_pkg::CTRL_OFFSET)
        && PWDATA_IN[flash_prog_pkg::CTRL_START_BIT] && !busy;
    assign PREADY_OUT = 1'b1;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == flash_prog_pkg::CTRL_OFFSET) || (a == flash_prog_pkg::ADDR_OFFSET)
            || (a == flash_prog_pkg::DATA_OFFSET) || (a == flash_prog_pkg::STATUS_OFFSET)
            || (a == flash_prog_pkg::TIMING_OFFSET);
    endfunction
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped(PADDR_IN);

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            op_reg <= flash_prog_pkg::OP_READ;
        end else if (start) begin
            op_reg <= flash_prog_pkg::flash_op_t'(PWDATA_IN[flash_prog_pkg::CTRL_OP_LSB +: flash_prog_pkg::CTRL_OP_WIDTH]);
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            hold_reg <= HOLD_DEFAULT;
        end else if (wr && !busy) begin
            if (PADDR_IN == flash_prog_pkg::ADDR_OFFSET) begin
                addr_reg <= PWDATA_IN[15:0];
            end else if (PADDR_IN == flash_prog_pkg::DATA_OFFSET) begin
                wdata_reg <= PWDATA_IN[7:0];
            end else if (PADDR_IN == flash_prog_pkg::TIMING_OFFSET) begin
                hold_reg <= (PWDATA_IN[15:0] == 16'h0000) ? 16'h0001 : PWDATA_IN[15:0];
            end
        end
    end

    always_comb begin
        PRDATA_OUT = 32'h0000_0000;
        if (PADDR_IN == flash_prog_pkg::CTRL_OFFSET) begin
            PRDATA_OUT[flash_prog_pkg::CTRL_OP_LSB +: flash_prog_pkg::CTRL_OP_WIDTH] = op_reg;
        end else if (PADDR_IN == flash_prog_pkg::ADDR_OFFSET) begin
            PRDATA_OUT[15:0] = addr_reg;
        end else if (PADDR_IN == flash_prog_pkg::DATA_OFFSET) begin
            PRDATA_OUT[7:0] = wdata_reg;
            PRDATA_OUT[15:8] = rdata_reg;
        end else if (PADDR_IN == flash_prog_pkg::STATUS_OFFSET) begin
            PRDATA_OUT[flash_prog_pkg::STATUS_BUSY_BIT] = busy;
            PRDATA_OUT[flash_prog_pkg::STATUS_DONE_BIT] = done_reg;
            PRDATA_OUT[flash_prog_pkg::STATUS_MISMATCH_BIT] = mismatch_reg;
        end else if (PADDR_IN == flash_prog_pkg::TIMING_OFFSET) begin
            PRDATA_OUT[15:0] = hold_reg;
        end
    end

    // ****************************************
    // Data input synchroniser
    // ****************************************
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= DATA_IN;
            sync2_reg <= sync1_reg;
        end
    end

    // ****************************************
    // Operation sequencer
    // ****************************************
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            state_reg <= flash_prog_pkg::ST_IDLE;
            count_reg <= 16'h0000;
        end else begin
            case (state_reg)
                flash_prog_pkg::ST_IDLE: begin
                    if (start) begin
                        state_reg <= flash_prog_pkg::ST_SETUP;
                    end
                end
                flash_prog_pkg::ST_SETUP: begin
                    count_reg <= hold_reg;
                    state_reg <= flash_prog_pkg::ST_HOLD;
                end
                flash_prog_pkg::ST_HOLD: begin
                    if (count_reg == 16'h0001) begin
                        state_reg <= flash_prog_pkg::ST_DONE;
                    end
                    count_reg <= count_reg - 16'h0001;
                end
                default: begin
                    state_reg <= flash_prog_pkg::ST_IDLE;
                end
            endcase
        end
    end

    logic is_verify;
    assign is_verify = (op_reg == flash_prog_pkg::OP_PROGRAM_VERIFY)
        || (op_reg == flash_prog_pkg::OP_ERASE_VERIFY);

    // Capture read data and compare on verify; done set wins over clear
    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            rdata_reg <= 8'h00;
            done_reg <= 1'b0;
            mismatch_reg <= 1'b0;
            last_prog_reg <= 8'h00;
        end else if (state_reg == flash_prog_pkg::ST_DONE) begin
            done_reg <= 1'b1;
            if (op_reg == flash_prog_pkg::OP_PROGRAM) begin
                last_prog_reg <= wdata_reg;
            end
            if (op_reg == flash_prog_pkg::OP_READ || is_verify) begin
                rdata_reg <= sync2_reg;
            end
            if (op_reg == flash_prog_pkg::OP_PROGRAM_VERIFY) begin
                mismatch_reg <= (sync2_reg != last_prog_reg);
            end else if (op_reg == flash_prog_pkg::OP_ERASE_VERIFY) begin
                mismatch_reg <= (sync2_reg != flash_prog_pkg::ERASE_DATA);
            end
        end else if (start) begin
            done_reg <= 1'b0;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    logic active;
    assign active = (state_reg == flash_prog_pkg::ST_HOLD) || (state_reg == flash_prog_pkg::ST_SETUP);

    always_ff @(posedge CLOCK_IN) begin
        if (RESET_IN) begin
            PINS_OUT <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                          flash_prog_pkg::SUPPLY_LOGIC_HIGH};
            ADDR_OUT <= 16'h0000;
            DATA_OUT <= 8'h00;
            DATA_OE_N_OUT <= 1'b1;
        end else begin
            PINS_OUT.reset_pin <= 1'b1;
            PINS_OUT.addr_latch_strobe <= 1'b0;
            PINS_OUT.program_store_strobe_n <= 1'b1;
            PINS_OUT.mode_pin_b <= 1'b0;
            PINS_OUT.mode_pin_c <= 1'b0;
            PINS_OUT.mode_pin_d <= 1'b0;
            ADDR_OUT <= addr_reg;
            DATA_OUT <= wdata_reg;
            DATA_OE_N_OUT <= 1'b1;
            PINS_OUT.erase_select_pin <= 1'b0;
            PINS_OUT.chip_select_n <= 1'b1;
            PINS_OUT.output_gate_n <= 1'b1;
            PINS_OUT.supply <= flash_prog_pkg::SUPPLY_LOGIC_HIGH;
            if (active) begin
                case (op_reg)
                    flash_prog_pkg::OP_READ: begin
                        PINS_OUT.chip_select_n <= 1'b0;
                        PINS_OUT.output_gate_n <= 1'b0;
                    end
                    flash_prog_pkg::OP_OUT_DISABLE: begin
                        PINS_OUT.chip_select_n <= 1'b0;
                    end
                    flash_prog_pkg::OP_PROGRAM: begin
                        PINS_OUT.chip_select_n <= 1'b0;
                        PINS_OUT.supply <= flash_prog_pkg::SUPPLY_PROGRAM;
                        DATA_OE_N_OUT <= 1'b0;
                    end
                    flash_prog_pkg::OP_PROGRAM_VERIFY: begin
                        PINS_OUT.output_gate_n <= 1'b0;
                        PINS_OUT.supply <= flash_prog_pkg::SUPPLY_PROGRAM;
                    end
                    flash_prog_pkg::OP_ERASE: begin
                        PINS_OUT.erase_select_pin <= 1'b1;
                        PINS_OUT.chip_select_n <= 1'b0;
                        PINS_OUT.output_gate_n <= 1'b1;
                        PINS_OUT.supply <= flash_prog_pkg::SUPPLY_ERASE;
                        ADDR_OUT <= {addr_reg[15:1], 1'b0};
                        DATA_OUT <= flash_prog_pkg::ERASE_DATA;
                        DATA_OE_N_OUT <= 1'b0;
                    end
                    flash_prog_pkg::OP_ERASE_VERIFY: begin
                        PINS_OUT.erase_select_pin <= 1'b1;
                        PINS_OUT.output_gate_n <= 1'b0;
                        PINS_OUT.supply <= flash_prog_pkg::SUPPLY_ERASE;
                    end
                    default: begin
                        PINS_OUT.supply <= flash_prog_pkg::SUPPLY_PROGRAM;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/flash_prog_pkg.sv
// Package for the flash programming port controller
package flash_prog_pkg;
    // ****************************************
    // Register map (APB, byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] ADDR_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;
    localparam logic [7:0] TIMING_OFFSET = 8'h10;
    // Control fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_OP_LSB = 4;
    localparam int CTRL_OP_WIDTH = 3;
    // Status fields
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;
    localparam int STATUS_MISMATCH_BIT = 2;
    // Device side constants
    localparam logic [15:0] SECURITY_ADDR = 16'hffff;
    localparam logic [7:0] ERASE_DATA = 8'hff;
    // Timing: default hold of pin levels, in ns
    localparam int HOLD_TIME_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [15:0] HOLD_RESET = 16'(HOLD_CYCLES);

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_OUT_DISABLE = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_PROGRAM_VERIFY = 3'h3,
        OP_ERASE = 3'h4,
        OP_ERASE_VERIFY = 3'h5,
        OP_INHIBIT = 3'h6
    } flash_op_t;

    // Supply pin level classes
    typedef enum logic [1:0] {
        SUPPLY_LOGIC_HIGH = 2'h0,
        SUPPLY_PROGRAM = 2'h1,
        SUPPLY_ERASE = 2'h2
    } supply_level_t;

    // Mode and control pin group driven to the device
    typedef struct packed {
        logic reset_pin;
        logic addr_latch_strobe;
        logic program_store_strobe_n;
        logic erase_select_pin;
        logic mode_pin_b;
        logic mode_pin_c;
        logic mode_pin_d;
        logic chip_select_n;
        logic output_gate_n;
        supply_level_t supply;
    } ctrl_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_HOLD = 2'b11,
        ST_DONE = 2'b10
    } seq_state_t;
endpackage

// file: test/flash_prog_host_asserts.sv
// Checker for the flash programming port controller
`timescale 1ns/1ps
`default_nettype none
module flash_prog_host_asserts (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire flash_prog_pkg::ctrl_pins_t PINS_OUT,
    input wire logic [15:0] ADDR_OUT,
    input wire logic [7:0] DATA_OUT,
    input wire logic DATA_OE_N_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    logic acc;
    logic mapped;
    logic prg;
    logic ers;
    logic hi;
    assign acc = PSEL_IN && PENABLE_IN;
    assign mapped = PADDR_IN inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    assign prg = PINS_OUT.supply == flash_prog_pkg::SUPPLY_PROGRAM;
    assign ers = PINS_OUT.supply == flash_prog_pkg::SUPPLY_ERASE;
    assign hi = PINS_OUT.supply == flash_prog_pkg::SUPPLY_LOGIC_HIGH;
    AST_MODE: assert property (PINS_OUT.reset_pin && !PINS_OUT.addr_latch_strobe
        && PINS_OUT.program_store_strobe_n) else $error("flash mode levels lost");
    AST_AUX_LOW: assert property (!(PINS_OUT.mode_pin_b || PINS_OUT.mode_pin_c
        || PINS_OUT.mode_pin_d)) else $error("spare control pin high");
    AST_ERSEL: assert property (PINS_OUT.erase_select_pin |-> ers)
        else $error("erase select outside erase level");
    AST_RD_FREE: assert property (!PINS_OUT.output_gate_n && (PINS_OUT.chip_select_n || hi)
        |-> DATA_OE_N_OUT) else $error("controller drives data during a read");
    AST_PRG_DRV: assert property (prg && !PINS_OUT.chip_select_n && PINS_OUT.output_gate_n
        |-> !DATA_OE_N_OUT) else $error("program without data drive");
    AST_ERASE: assert property (PINS_OUT.erase_select_pin && !PINS_OUT.chip_select_n
        |-> !ADDR_OUT[0] && DATA_OUT == 8'hff && !DATA_OE_N_OUT && PINS_OUT.output_gate_n)
        else $error("bad erase form");
    AST_ADDR_HOLD: assert property ($past(!PINS_OUT.chip_select_n) && !PINS_OUT.chip_select_n
        |-> $stable(ADDR_OUT)) else $error("address moved during an operation");
    AST_READY: assert property (acc |-> PREADY_OUT) else $error("no ready in access phase");
    AST_UNMAPPED: assert property (acc && !mapped |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
        else $error("unmapped access not refused");
endmodule
bind flash_prog_host flash_prog_host_asserts chk (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PINS_OUT(PINS_OUT), .ADDR_OUT(ADDR_OUT),
    .DATA_OUT(DATA_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT));
`default_nettype wire

// file: test/flash_port_model.sv
// Behavioural programming port of the target device
`timescale 1ns/1ps
`default_nettype none
module flash_port_model (
    input wire logic clk_in,
    input wire flash_prog_pkg::ctrl_pins_t pins_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic data_oe_n_in,
    output logic [7:0] port_out
);
    // Low address byte only; upper bits alias
    logic [7:0] mem [0:255];
    // Encryption enable bit and key are arbitrary; enabled when the bit is low
    localparam int ENC_BIT = 2;
    localparam logic [7:0] ENC_KEY = 8'h3c;
    logic [7:0] sec_reg = 8'hff;
    logic [7:0] last = 8'h00;
    logic fm, es, cs, oe, hi, prg, ers, drive, is_sec;
    logic [7:0] rd;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'hff;
    assign fm = pins_in.reset_pin && !pins_in.addr_latch_strobe && pins_in.program_store_strobe_n
        && !pins_in.mode_pin_b && !pins_in.mode_pin_c && !pins_in.mode_pin_d;
    assign es = pins_in.erase_select_pin;
    assign cs = pins_in.chip_select_n;
    assign oe = pins_in.output_gate_n;
    assign hi = pins_in.supply == flash_prog_pkg::SUPPLY_LOGIC_HIGH;
    assign prg = pins_in.supply == flash_prog_pkg::SUPPLY_PROGRAM;
    assign ers = pins_in.supply == flash_prog_pkg::SUPPLY_ERASE;
    assign is_sec = addr_in == 16'hffff;
    assign rd = is_sec ? sec_reg
        : (sec_reg[ENC_BIT] ? mem[addr_in[7:0]] : mem[addr_in[7:0]] ^ ENC_KEY);
    assign drive = fm && !oe && ((!es && hi && !cs) || (!es && prg && cs) || (es && ers && cs));
    // Lock low scrambles every read; released port shows no stale byte
    assign port_out = drive ? (sec_reg[0] ? rd : ~rd) : (!data_oe_n_in ? data_in : ~last);
    always @(posedge clk_in) begin
        last <= port_out;
        if (fm && !es && prg && !cs && oe && sec_reg[0]) begin
            if (is_sec) sec_reg <= sec_reg & data_in;
            else mem[addr_in[7:0]] <= mem[addr_in[7:0]] & data_in;
        end
        if (fm && es && ers && !cs && oe && !addr_in[0] && data_in == 8'hff) begin
            sec_reg <= 8'hff;
            for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
        end
    end
endmodule
`default_nettype wire

// file: test/flash_prog_host_tb.sv
// Self-checking bench for the flash programming port controller
`timescale 1ns/1ps
`default_nettype none
module flash_prog_host_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, oe_n, slv;
    flash_prog_pkg::ctrl_pins_t pins;
    logic [15:0] faddr;
    logic [7:0] fdata, port, got;
    logic mis;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    flash_prog_host #(.HOLD_DEFAULT(16'h0004)) dut (.CLOCK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PINS_OUT(pins), .ADDR_OUT(faddr),
        .DATA_OUT(fdata), .DATA_OE_N_OUT(oe_n), .DATA_IN(port));
    flash_port_model dev (.clk_in(clk), .pins_in(pins), .addr_in(faddr), .data_in(fdata),
        .data_oe_n_in(oe_n), .port_out(port));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic rdy;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            rdy = pready;
            rd = prdata;
            slv = pslverr;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic op(input logic [2:0] code, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        apb(1'b1, flash_prog_pkg::ADDR_OFFSET, {16'h0, a});
        apb(1'b1, flash_prog_pkg::DATA_OFFSET, {24'h0, d});
        apb(1'b1, flash_prog_pkg::CTRL_OFFSET, {25'h0, code, 4'h1});
        do begin
            apb(1'b0, flash_prog_pkg::STATUS_OFFSET, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 50);
        if (rd[1] !== 1'b1) err_count++;
        mis = rd[2];
        apb(1'b0, flash_prog_pkg::DATA_OFFSET, 32'h0);
        got = rd[15:8];
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("idle pins", 32'({pins.reset_pin, pins.addr_latch_strobe, pins.program_store_strobe_n,
            pins.chip_select_n, pins.output_gate_n, oe_n}), 32'h2f);
        apb(1'b0, flash_prog_pkg::TIMING_OFFSET, 32'h0);
        check("timing", rd, 32'h4);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped slverr", 32'(slv), 32'h1);
        $display("test registers done");
        op(3'h4, 16'h0000, 8'hff);
        op(3'h5, 16'h1234, 8'h00);
        check("erase verify", {got, 7'h0, mis}, {8'hff, 8'h00});
        op(3'h2, 16'h1234, 8'h5a);
        op(3'h3, 16'h1234, 8'h00);
        check("program verify", {got, 7'h0, mis}, {8'h5a, 8'h00});
        op(3'h2, 16'h1234, 8'hff);
        op(3'h6, 16'h1234, 8'h00);
        op(3'h1, 16'h1234, 8'h00);
        op(3'h0, 16'h1234, 8'h00);
        check("read after inhibit", 32'(got), 32'h5a);
        op(3'h5, 16'h1234, 8'h00);
        check("erase verify flag", 32'(mis), 32'h1);
        $display("test program erase done");
        op(3'h2, 16'hffff, 8'hfe);
        op(3'h0, 16'h1234, 8'h00);
        check("locked read hidden", 32'(got === 8'h5a), 32'h0);
        op(3'h4, 16'h0000, 8'hff);
        op(3'h0, 16'hffff, 8'h00);
        check("security after erase", 32'(got), 32'hff);
        op(3'h0, 16'h1234, 8'h00);
        check("code after erase", 32'(got), 32'hff);
        op(3'h2, 16'h1234, 8'h5a);
        op(3'h2, 16'hffff, 8'hfb);
        op(3'h0, 16'h1234, 8'h00);
        check("encoded read", 32'(got), 32'h66);
        op(3'h4, 16'h0000, 8'hff);
        op(3'h0, 16'hffff, 8'h00);
        check("encryption cleared", 32'(got), 32'hff);
        $display("test security done");
        complete_run();
    end
endmodule
`default_nettype wire
